// *** design/rlpf_top.sv ***
// Link and power controller of a dual-channel SuperSpeed redriver, with an AHB-Lite slave.
// Assumes analog front ends for receiver detect, LFPS squelch and three-state pin sensing.
// What this block does
// - Power-up or enable toggle: inputs high impedance, then probe far-end receivers.
// - Receivers found on both channels: enable normal transmit and receive terminations.
// - Detection failed: float transmitter of each channel not found, low power, retry every 12 ms.
// - In U2/U3, repeat detection periodically while keeping input termination.
// - U2/U3 detect found returns to low power, else drop termination, redetect.
// - Input below LFPS minimum threshold puts that transmitter into electrical idle.
// - Input above LFPS maximum threshold leaves idle and passes signal again.
// - Idle entry and exit complete in under 6 ns.
// - Active only with enable high and both ends detected; apply selected settings.
// - Enable falling, or power-up with enable low, enters sleep with terminations off.
// - Sleep entered within 2 us; leave for detection within 100 us.
// - Enable pin one means normal operation, zero means sleep.
// - Link break or failed detection: receiver-detect mode, circuits down, inputs Hi-Z.
// - Receiver-detect mode reconnects on its own without configuration.
// - Internal timers track U2/U3 entry and switch off selected circuitry.
// - LFPS activity in U2/U3 returns the device to active mode.
// - Equalization pin: floating 0 dB, low 7 dB, high 15 dB.
// - Swing pin: floating 1042, low 908, high 1127 mVpp.
// - De-emphasis pin with swing pin selects the de-emphasis level.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
module rlpf_top #(
   parameter int RETRY_CYCLES    = rlpf_pkg::RETRY_CYC,
   parameter int WAKE_CYCLES     = rlpf_pkg::WAKE_CYC,
   parameter int U_ENTRY_CYCLES  = rlpf_pkg::U_ENTRY_CYC,
   parameter int U_PERIOD_CYCLES = rlpf_pkg::U_PERIOD_CYC
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Board enable/sleep pin
   input  wire logic        en_sleep_pin,
   // Three-state pin sensing, per channel: level under weak pull-up and under weak pull-down
   input  wire logic [1:0]  eq_sense_up,
   input  wire logic [1:0]  eq_sense_dn,
   input  wire logic [1:0]  os_sense_up,
   input  wire logic [1:0]  os_sense_dn,
   input  wire logic [1:0]  de_sense_up,
   input  wire logic [1:0]  de_sense_dn,
   // Analog detect and squelch comparators
   input  wire logic [1:0]  rxdet_found,
   input  wire logic [1:0]  lfps_below_min,
   input  wire logic [1:0]  lfps_above_max,
   // Terminations and driver control
   output logic      [1:0]  rx_term_en,
   output logic      [1:0]  tx_term_en,
   output logic      [1:0]  tx_float,
   output logic      [1:0]  tx_elec_idle,
   output logic      [1:0]  rxdet_probe,
   // Power modes
   output logic             low_power,
   output logic             asleep,
   output logic             active_mode,
   output logic             ulp_mode,
   // Selected settings, per channel
   output logic      [3:0]  rx_equalization_select,
   output logic      [3:0]  output_swing_select,
   output logic      [5:0]  tx_deemphasis_select
);
   import rlpf_pkg::*;

   generate
      if (RETRY_CYCLES < 2 || RETRY_CYCLES >= 2**CNT_W || WAKE_CYCLES < 2 ||
          WAKE_CYCLES >= 2**CNT_W || U_ENTRY_CYCLES < 2 || U_ENTRY_CYCLES >= 2**CNT_W ||
          U_PERIOD_CYCLES <= DET_CYC || U_PERIOD_CYCLES >= 2**CNT_W) begin : g_bad
         $error("rlpf_top: cycle count parameter out of range");
      end
   endgenerate

   localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYCLES - 1);
   localparam logic [CNT_W-1:0] WAKE_LAST  = CNT_W'(WAKE_CYCLES - 1);
   localparam logic [CNT_W-1:0] UENT_LAST  = CNT_W'(U_ENTRY_CYCLES - 1);
   localparam logic [CNT_W-1:0] UPER_LAST  = CNT_W'(U_PERIOD_CYCLES - 1);
   localparam logic [CNT_W-1:0] DET_LAST   = CNT_W'(DET_CYC - 1);

   rlpf_state_s q_ff;
   rlpf_state_s nxt_q;

   // Sense pair to code: up only floats; both low is driven low; both high is driven high
   function automatic rlpf_pin_t pin_code(input logic up, input logic dn);
      rlpf_pin_t c;
      c = PIN_FLOAT;
      if (!up && !dn) begin
         c = PIN_LOW;
      end else if (up && dn) begin
         c = PIN_HIGH;
      end
      return c;
   endfunction

   function automatic rlpf_de_e de_level(input rlpf_pin_t de, input rlpf_pin_t os);
      rlpf_de_e r;
      r = DE_0DB;
      if (de == PIN_LOW) begin
         r = (os == PIN_LOW) ? DE_M2P2 : ((os == PIN_HIGH) ? DE_M4P4 : DE_M3P5);
      end else if (de == PIN_HIGH) begin
         r = (os == PIN_LOW) ? DE_M5P2 : DE_M6P0;
      end
      return r;
   endfunction

   logic        addr_take;
   logic        sw_restart;
   logic [11:0] cfg_raw;

   assign addr_take  = hsel && hready && htrans[1];
   assign sw_restart = q_ff.a_valid && q_ff.a_wr && (q_ff.a_addr == REG_CTRL) &&
                       hwdata[CTRL_RESTART];
   assign cfg_raw    = {de_sense_dn, de_sense_up, os_sense_dn, os_sense_up,
                        eq_sense_dn, eq_sense_up};

   always_comb begin
      nxt_q = q_ff;
      // Two-flop synchronisers for pins and the slow detect comparator
      nxt_q.en_s1    = en_sleep_pin;
      nxt_q.en_s2    = q_ff.en_s1;
      nxt_q.found_s1 = rxdet_found;
      nxt_q.found_s2 = q_ff.found_s1;
      nxt_q.cfg_s1   = cfg_raw;
      nxt_q.cfg_s2   = q_ff.cfg_s1;
      // Squelch comparators share this clock, so one flop keeps idle turnaround to one cycle
      for (int ch = 0; ch < NCH; ch++) begin
         if (lfps_below_min[ch]) begin
            nxt_q.idle[ch] = 1'b1;
         end else if (lfps_above_max[ch]) begin
            nxt_q.idle[ch] = 1'b0;
         end
      end
      // Time both channels have sat in electrical idle while active
      if (q_ff.mode == M_ACTIVE && (&q_ff.idle)) begin
         if (q_ff.idle_cnt != UENT_LAST) begin
            nxt_q.idle_cnt = q_ff.idle_cnt + 1'b1;
         end
      end else begin
         nxt_q.idle_cnt = '0;
      end
      nxt_q.cnt = q_ff.cnt + 1'b1;
      case (q_ff.mode)
         M_SLEEP: begin
            nxt_q.cnt = '0;
            if (q_ff.en_s2) begin
               nxt_q.mode = M_WAKE;
            end
         end
         M_WAKE: begin
            if (q_ff.cnt == WAKE_LAST) begin
               nxt_q.cnt  = '0;
               nxt_q.mode = M_DETECT;
               // Settings are latched once per wake so a drifting pin cannot retune live traffic
               for (int ch = 0; ch < NCH; ch++) begin
                  nxt_q.eq[2*ch +: 2] = pin_code(q_ff.cfg_s2[ch], q_ff.cfg_s2[2+ch]);
                  nxt_q.os[2*ch +: 2] = pin_code(q_ff.cfg_s2[4+ch], q_ff.cfg_s2[6+ch]);
                  nxt_q.de[2*ch +: 2] = pin_code(q_ff.cfg_s2[8+ch], q_ff.cfg_s2[10+ch]);
               end
            end
         end
         M_DETECT: begin
            if (q_ff.cnt == DET_LAST) begin
               nxt_q.cnt   = '0;
               nxt_q.found = q_ff.found_s2;
               nxt_q.mode  = (&q_ff.found_s2) ? M_ACTIVE : M_RETRY;
            end
         end
         M_RETRY: begin
            if (q_ff.cnt == RETRY_LAST) begin
               nxt_q.cnt  = '0;
               nxt_q.mode = M_DETECT;
            end
         end
         M_ACTIVE: begin
            nxt_q.cnt = '0;
            if (q_ff.u_en && q_ff.idle_cnt == UENT_LAST) begin
               nxt_q.mode = M_ULP;
            end
         end
         M_ULP: begin
            if (~&q_ff.idle) begin
               nxt_q.cnt  = '0;
               nxt_q.mode = M_ACTIVE;
            end else if (q_ff.cnt == UPER_LAST) begin
               nxt_q.cnt  = '0;
               nxt_q.mode = M_UDET;
            end
         end
         M_UDET: begin
            if (q_ff.cnt == DET_LAST) begin
               nxt_q.cnt   = '0;
               nxt_q.found = q_ff.found_s2;
               nxt_q.mode  = (&q_ff.found_s2) ? M_ULP : M_DETECT;
            end
         end
         default: begin
            nxt_q.mode = M_SLEEP;
         end
      endcase
      // Software restart reruns detection unless asleep
      if (sw_restart && q_ff.mode != M_SLEEP && q_ff.mode != M_WAKE) begin
         nxt_q.cnt  = '0;
         nxt_q.mode = M_DETECT;
      end
      // Pin low overrides everything
      if (!q_ff.en_s2) begin
         nxt_q.cnt  = '0;
         nxt_q.mode = M_SLEEP;
      end
      // Analog controls follow the next mode so they change with it
      nxt_q.rx_term   = 2'h0;
      nxt_q.tx_term   = 2'h0;
      nxt_q.tx_float  = 2'h3;
      nxt_q.probe     = 2'h0;
      nxt_q.low_power = 1'b1;
      nxt_q.asleep    = (nxt_q.mode == M_SLEEP) || (nxt_q.mode == M_WAKE);
      nxt_q.active    = 1'b0;
      nxt_q.ulp       = 1'b0;
      case (nxt_q.mode)
         M_DETECT: begin
            nxt_q.probe = 2'h3;
         end
         M_RETRY: begin
            nxt_q.tx_float = ~nxt_q.found;
            nxt_q.tx_term  = nxt_q.found;
         end
         M_ACTIVE: begin
            nxt_q.rx_term   = 2'h3;
            nxt_q.tx_term   = 2'h3;
            nxt_q.tx_float  = 2'h0;
            nxt_q.low_power = 1'b0;
            nxt_q.active    = 1'b1;
         end
         M_ULP, M_UDET: begin
            nxt_q.rx_term  = 2'h3;
            nxt_q.tx_term  = 2'h3;
            nxt_q.tx_float = 2'h0;
            nxt_q.probe    = (nxt_q.mode == M_UDET) ? 2'h3 : 2'h0;
            nxt_q.ulp      = 1'b1;
         end
         default: begin
            nxt_q.tx_float = 2'h3;
         end
      endcase
      // Bus: address phase captured, write applied in the data phase, read data registered at the end of the address phase
      nxt_q.a_valid = addr_take;
      if (addr_take) begin
         nxt_q.a_wr   = hwrite;
         nxt_q.a_addr = haddr[7:0];
      end
      if (q_ff.a_valid && q_ff.a_wr && q_ff.a_addr == REG_CTRL) begin
         nxt_q.u_en = hwdata[CTRL_UEN];
      end
      nxt_q.rdata = 32'h0;
      if (addr_take && !hwrite) begin
         if (haddr[7:0] == REG_CTRL) begin
            nxt_q.rdata[CTRL_UEN] = q_ff.u_en;
         end else if (haddr[7:0] == REG_STAT) begin
            nxt_q.rdata[13:0] = {q_ff.en_s2, q_ff.asleep, q_ff.active, q_ff.ulp, q_ff.idle,
                                 q_ff.found, q_ff.rx_term, q_ff.tx_float, q_ff.mode[2:1]};
            nxt_q.rdata[16]   = q_ff.mode[0];
         end else if (haddr[7:0] == REG_CFG) begin
            nxt_q.rdata[11:0] = {q_ff.de, q_ff.os, q_ff.eq};
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q_ff          <= '0;
         q_ff.mode     <= M_SLEEP;
         q_ff.u_en     <= CTRL_UEN_RST;
         q_ff.tx_float <= 2'h3;
         q_ff.asleep   <= 1'b1;
         q_ff.low_power <= 1'b1;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // Outputs from flops, de-emphasis select decoded from them; hreadyout and hresp tied off
   assign hrdata       = q_ff.rdata;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign rx_term_en   = q_ff.rx_term;
   assign tx_term_en   = q_ff.tx_term;
   assign tx_float     = q_ff.tx_float;
   assign tx_elec_idle = q_ff.idle;
   assign rxdet_probe  = q_ff.probe;
   assign low_power    = q_ff.low_power;
   assign asleep       = q_ff.asleep;
   assign active_mode  = q_ff.active;
   assign ulp_mode     = q_ff.ulp;
   assign rx_equalization_select = q_ff.eq;
   assign output_swing_select    = q_ff.os;
   assign tx_deemphasis_select   = {de_level(q_ff.de[3:2], q_ff.os[3:2]),
                                    de_level(q_ff.de[1:0], q_ff.os[1:0])};

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence det_done_found;
      q_ff.mode == M_DETECT && q_ff.cnt == DET_LAST && (&q_ff.found_s2) &&
      q_ff.en_s2 && !sw_restart;
   endsequence
   sequence udet_done_miss;
      q_ff.mode == M_UDET && q_ff.cnt == DET_LAST && !(&q_ff.found_s2) &&
      q_ff.en_s2 && !sw_restart;
   endsequence

   // Outputs are registered from the next mode, so they match q_ff.mode in the same cycle
   sleep_entry_a: assert property (
      !q_ff.en_s2 |=> q_ff.mode == M_SLEEP && asleep && rx_term_en == 2'h0)
      else $error("sleep not entered after enable low");
   sleep_wake_a: assert property (
      q_ff.mode == M_SLEEP && q_ff.en_s2 |=> q_ff.mode == M_WAKE && asleep)
      else $error("no wake after enable high");
   detect_hiz_a: assert property (
      q_ff.mode == M_DETECT |-> rx_term_en == 2'h0 && rxdet_probe == 2'h3)
      else $error("input termination on during detect");
   found_active_a: assert property (
      det_done_found |=> active_mode && rx_term_en == 2'h3 && tx_term_en == 2'h3)
      else $error("both found but not active");
   retry_float_a: assert property (
      $rose(q_ff.mode == M_RETRY) |-> low_power && tx_float == ~q_ff.found &&
      rx_term_en == 2'h0)
      else $error("retry without float or low power");
   retry_redo_a: assert property (
      q_ff.mode == M_RETRY && q_ff.cnt == RETRY_LAST && q_ff.en_s2 && !sw_restart
      |=> q_ff.mode == M_DETECT && rxdet_probe == 2'h3)
      else $error("retry did not return to detect");
   udet_keep_a: assert property (
      q_ff.mode == M_UDET |-> rx_term_en == 2'h3 && rxdet_probe == 2'h3)
      else $error("termination dropped in low-power detect");
   udet_miss_a: assert property (
      udet_done_miss |=> q_ff.mode == M_DETECT ##1 rx_term_en == 2'h0)
      else $error("missed low-power detect did not redetect");
   udet_hit_a: assert property (
      q_ff.mode == M_UDET && q_ff.cnt == DET_LAST && (&q_ff.found_s2) && q_ff.en_s2 &&
      !sw_restart |=> ulp_mode && rxdet_probe == 2'h0 && rx_term_en == 2'h3)
      else $error("found in low-power detect but not back to low power");
   ulp_entry_a: assert property (
      q_ff.mode == M_ACTIVE && q_ff.u_en && q_ff.idle_cnt == UENT_LAST && q_ff.en_s2 &&
      !sw_restart |=> ulp_mode && !active_mode && rx_term_en == 2'h3)
      else $error("no low-power entry after idle time");
   cfg_static_a: assert property (
      q_ff.mode != M_WAKE |=> $stable(q_ff.eq) && $stable(q_ff.os) && $stable(q_ff.de))
      else $error("settings changed outside wake");
   idle_entry_a: assert property (lfps_below_min[0] |=> tx_elec_idle[0])
      else $error("idle entry late");
   idle_exit_a: assert property (lfps_above_max[1] && !lfps_below_min[1] |=> !tx_elec_idle[1])
      else $error("idle exit late");
   active_only_a: assert property (active_mode |-> $past(q_ff.en_s2) && (&q_ff.found))
      else $error("active without enable or detection");
   ulp_exit_a: assert property (
      q_ff.mode == M_ULP && (~&q_ff.idle) && q_ff.en_s2 && !sw_restart |=> active_mode)
      else $error("no return to active on activity");
   wake_bound_a: assert property (
      q_ff.mode == M_WAKE && q_ff.cnt == WAKE_LAST && q_ff.en_s2 |=> q_ff.mode == M_DETECT)
      else $error("wake exceeds bound");
endmodule

// *** shared/rlpf_pkg.sv ***
// Shared constants, encodings and the state record of the redriver link/power controller.
// Assumes a 200 MHz control clock; all times below are turned into cycle counts here.
package rlpf_pkg;
   localparam int CLK_MHZ        = 200;
   localparam int NCH            = 2;
   localparam int CNT_W          = 22;
   // Times in their own units, then derived cycle counts
   localparam int RETRY_MS       = 12;
   localparam int RETRY_CYC      = RETRY_MS * 1000 * CLK_MHZ;
   localparam int WAKE_US        = 100;
   localparam int WAKE_CYC       = WAKE_US * CLK_MHZ;
   localparam int SLEEP_US       = 2;
   localparam int SLEEP_CYC      = SLEEP_US * CLK_MHZ;
   localparam int IDLE_NS        = 6;
   localparam int IDLE_CYC_RAW   = (IDLE_NS * CLK_MHZ) / 1000;
   localparam int IDLE_CYC       = (IDLE_CYC_RAW < 1) ? 1 : IDLE_CYC_RAW;
   localparam int DET_CYC        = 64;
   localparam int U_ENTRY_CYC    = 2000;
   localparam int U_PERIOD_CYC   = 4000;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_CFG  = 8'h08;
   localparam int CTRL_RESTART   = 0;
   localparam int CTRL_UEN       = 1;
   localparam logic CTRL_UEN_RST = 1'b1;
   // Three-state pin codes
   typedef logic [1:0] rlpf_pin_t;
   localparam rlpf_pin_t PIN_FLOAT = 2'h0;
   localparam rlpf_pin_t PIN_LOW   = 2'h1;
   localparam rlpf_pin_t PIN_HIGH  = 2'h2;
   typedef enum logic [2:0] {M_SLEEP, M_WAKE, M_DETECT, M_RETRY, M_ACTIVE, M_ULP,
                             M_UDET} rlpf_mode_e;
   typedef enum logic [2:0] {DE_0DB, DE_M2P2, DE_M3P5, DE_M4P4, DE_M5P2, DE_M6P0} rlpf_de_e;
   typedef struct packed {
      logic             en_s1;
      logic             en_s2;
      logic [1:0]       found_s1;
      logic [1:0]       found_s2;
      logic [11:0]      cfg_s1;
      logic [11:0]      cfg_s2;
      rlpf_mode_e       mode;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] idle_cnt;
      logic [1:0]       idle;
      logic [1:0]       found;
      logic [3:0]       eq;
      logic [3:0]       os;
      logic [3:0]       de;
      logic             u_en;
      logic             a_valid;
      logic             a_wr;
      logic [7:0]       a_addr;
      logic [31:0]      rdata;
      logic [1:0]       rx_term;
      logic [1:0]       tx_term;
      logic [1:0]       tx_float;
      logic [1:0]       probe;
      logic             low_power;
      logic             asleep;
      logic             active;
      logic             ulp;
   } rlpf_state_s;
endpackage

// *** tb/rlpf_far_model.sv ***
// Far side of the redriver: board straps, the far USB receivers and their LFPS signalling.
// Assumes the controller probes with rxdet_probe and reads straps through pull-up/down sensing.
`timescale 1ns/10ps
module rlpf_far_model (
   // Strap settings, 2-bit pin code per channel
   input  wire logic [3:0] eq_code,
   input  wire logic [3:0] os_code,
   input  wire logic [3:0] de_code,
   // Far-end receiver presence and link activity per channel
   input  wire logic [1:0] present,
   input  wire logic [1:0] signalling,
   // Probe from the redriver
   input  wire logic [1:0] rxdet_probe,
   // Strap sensing
   output logic      [1:0] eq_sense_up,
   output logic      [1:0] eq_sense_dn,
   output logic      [1:0] os_sense_up,
   output logic      [1:0] os_sense_dn,
   output logic      [1:0] de_sense_up,
   output logic      [1:0] de_sense_dn,
   // Analog comparators
   output logic      [1:0] rxdet_found,
   output logic      [1:0] lfps_below_min,
   output logic      [1:0] lfps_above_max
);
   import rlpf_pkg::*;
   // Floating pin reads high under pull-up, low under pull-down
   function automatic logic [1:0] dn_up(input logic [1:0] c);
      return (c == PIN_LOW) ? 2'b00 : (c == PIN_HIGH) ? 2'b11 : 2'b01;
   endfunction
   for (genvar c = 0; c < 2; c++) begin : g_ch
      assign {eq_sense_dn[c], eq_sense_up[c]} = dn_up(eq_code[2*c +: 2]);
      assign {os_sense_dn[c], os_sense_up[c]} = dn_up(os_code[2*c +: 2]);
      assign {de_sense_dn[c], de_sense_up[c]} = dn_up(de_code[2*c +: 2]);
   end
   // Host on host pins, device on device pins: presence seen only while probed
   assign rxdet_found    = present & rxdet_probe;
   assign lfps_above_max = signalling;
   assign lfps_below_min = ~signalling;
endmodule

// *** tb/tb.sv ***
// Self-checking bench of the redriver link/power controller, polling state over AHB-Lite.
// Assumes the far-side model for straps and comparators; long counts shortened by parameters.
`timescale 1ns/10ps
module tb;
   import rlpf_pkg::*;
   localparam int RETRY_P = 200;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        en_sleep_pin = 1'b0;
   logic [3:0]  eq_code = 4'h0;
   logic [3:0]  os_code = 4'h0;
   logic [3:0]  de_code = 4'h0;
   logic [1:0]  present = 2'h3;
   logic [1:0]  signalling = 2'h3;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, low_power, asleep, active_mode, ulp_mode;
   wire  [1:0]  eq_up, eq_dn, os_up, os_dn, de_up, de_dn, found, below, above;
   wire  [1:0]  rx_term_en, tx_term_en, tx_float, tx_elec_idle, rxdet_probe;
   wire  [3:0]  eq_sel, os_sel;
   wire  [5:0]  de_sel;
   int          err_count = 0;
   int          samples_checked = 0;
   logic [31:0] rd;
   time         t0;
   // Strap rows: eq, os, de codes and the expected de-emphasis selection
   logic [3:0]  eq_t [3] = '{4'h9, 4'h0, 4'h6};
   logic [3:0]  os_t [3] = '{4'h2, 4'h5, 4'h4};
   logic [3:0]  de_t [3] = '{4'h9, 4'h8, 4'h5};
   logic [5:0]  dx_t [3] = '{6'h2b, 6'h20, 6'h0a};

   always #2.5 mclk = ~mclk;

   rlpf_top #(.RETRY_CYCLES(RETRY_P), .WAKE_CYCLES(10), .U_ENTRY_CYCLES(20),
              .U_PERIOD_CYCLES(100)) rlpf_top_i (
      .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .en_sleep_pin(en_sleep_pin),
      .eq_sense_up(eq_up), .eq_sense_dn(eq_dn), .os_sense_up(os_up), .os_sense_dn(os_dn),
      .de_sense_up(de_up), .de_sense_dn(de_dn), .rxdet_found(found),
      .lfps_below_min(below), .lfps_above_max(above), .rx_term_en(rx_term_en),
      .tx_term_en(tx_term_en), .tx_float(tx_float), .tx_elec_idle(tx_elec_idle),
      .rxdet_probe(rxdet_probe), .low_power(low_power), .asleep(asleep),
      .active_mode(active_mode), .ulp_mode(ulp_mode), .rx_equalization_select(eq_sel),
      .output_swing_select(os_sel), .tx_deemphasis_select(de_sel));

   rlpf_far_model rlpf_far_model_i (
      .eq_code(eq_code), .os_code(os_code), .de_code(de_code), .present(present),
      .signalling(signalling), .rxdet_probe(rxdet_probe), .eq_sense_up(eq_up),
      .eq_sense_dn(eq_dn), .os_sense_up(os_up), .os_sense_dn(os_dn), .de_sense_up(de_up),
      .de_sense_dn(de_dn), .rxdet_found(found), .lfps_below_min(below),
      .lfps_above_max(above));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One single AHB-Lite word transfer; read data taken at the data-phase edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask

   // Polls the status word until the mode shows up or the poll limit runs out
   task automatic wait_mode(input rlpf_mode_e m, input int limit);
      logic [31:0] s;
      int          n;
      n = 0;
      do begin
         ahb(1'b0, REG_STAT, 32'h0, s);
         n++;
      end while ({s[1:0], s[16]} !== m && n < limit);
      chk({29'h0, s[1:0], s[16]}, {29'h0, m});
   endtask

   task automatic report_and_stop;
      $display("TB: checks=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      chk({27'h0, hresp, asleep, low_power, tx_float}, 32'hf);
      chk({30'h0, rx_term_en}, 32'h0);
      ahb(1'b0, REG_CTRL, 32'h0, rd);
      chk(rd, 32'h2);
      for (int i = 0; i < 3; i++) begin
         en_sleep_pin <= 1'b0;
         wait_mode(M_SLEEP, 130);
         chk({28'h0, rx_term_en, tx_term_en}, 32'h0);
         eq_code <= eq_t[i];
         os_code <= os_t[i];
         de_code <= de_t[i];
         en_sleep_pin <= 1'b1;
         wait_mode(M_DETECT, 30);
         chk({28'h0, rxdet_probe, rx_term_en}, 32'hc);
         wait_mode(M_ACTIVE, 40);
         chk({27'h0, active_mode, rx_term_en, tx_term_en}, 32'h1f);
         chk({24'h0, os_sel, eq_sel}, {24'h0, os_t[i], eq_t[i]});
         chk({26'h0, de_sel}, {26'h0, dx_t[i]});
      end
      eq_code <= 4'h0;
      repeat (10) @(posedge mclk);
      chk({28'h0, eq_sel}, 32'h6);
      signalling <= 2'b10;
      @(posedge mclk);
      #1 chk({30'h0, tx_elec_idle}, 32'h1);
      @(posedge mclk);
      signalling <= 2'b11;
      @(posedge mclk);
      #1 chk({30'h0, tx_elec_idle}, 32'h0);
      @(posedge mclk);
      signalling <= 2'b00;
      wait_mode(M_ULP, 15);
      chk({31'h0, ulp_mode}, 32'h1);
      wait_mode(M_UDET, 45);
      chk({28'h0, rxdet_probe, rx_term_en}, 32'hf);
      wait_mode(M_ULP, 30);
      signalling <= 2'b10;
      wait_mode(M_ACTIVE, 2);
      signalling <= 2'b00;
      wait_mode(M_ULP, 15);
      present <= 2'b01;
      wait_mode(M_DETECT, 70);
      chk({30'h0, rx_term_en}, 32'h0);
      wait_mode(M_RETRY, 30);
      t0 = $time;
      chk({29'h0, low_power, tx_float}, 32'h6);
      present <= 2'b11;
      signalling <= 2'b11;
      wait_mode(M_DETECT, 80);
      chk(32'(($time - t0) / 5 + 3 >= RETRY_P && ($time - t0) / 5 <= RETRY_P + 3), 32'h1);
      wait_mode(M_ACTIVE, 30);
      ahb(1'b1, REG_CTRL, 32'h0, rd);
      ahb(1'b0, REG_CTRL, 32'h0, rd);
      chk(rd, 32'h0);
      signalling <= 2'b00;
      repeat (40) @(posedge mclk);
      wait_mode(M_ACTIVE, 1);
      ahb(1'b1, REG_CTRL, 32'h3, rd);
      signalling <= 2'b11;
      wait_mode(M_DETECT, 3);
      wait_mode(M_ACTIVE, 30);
      ahb(1'b1, 8'h0c, 32'hffffffff, rd);
      ahb(1'b0, 8'h0c, 32'h0, rd);
      chk(rd, 32'h0);
      ahb(1'b0, REG_CFG, 32'h0, rd);
      chk(rd, {20'h0, de_t[2], os_t[2], eq_t[2]});
      en_sleep_pin <= 1'b0;
      wait_mode(M_SLEEP, 130);
      chk({27'h0, asleep, rx_term_en, tx_term_en}, 32'h10);
      report_and_stop();
   end
endmodule
